/* File: rtl/pllsy_ctrl.sv */
// PLL synthesis control: dividers, reference switchover, serial reconfiguration
//
// Overview of operation
// - One pre-scale and one multiply, 1 to 512
// - Loop targets input times m over n
// - Each output has its own post-scale divider
// - Two regional, four global, four external, 1..1024
// - Non-50% duty limits divide to 1..512
// - Lost primary moves reference to secondary
// - Manual switch input; needed beyond 20% mismatch
// - Manual switch works for equal or different frequencies
// - Switchover glitch-free, oscillator keeps running
// - Relock within 100 us after switch
// - Runtime change of dividers and delays
// - Serial chain on its own shift clock
// - Last bit loads chain into active config
// - Asynchronous clear of the shift chain
// - Reconfiguration under 20 us at 22 MHz; here scan_clk_in is sampled on clk_in, so it can run at 10 MHz at most
// - Bandwidth settings not reachable via chain
// - Bandwidth settable via pump, filter, capacitor, m
// - External counters only on external-output instances
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module pllsy_ctrl
    import pllsy_pkg::*;
#(
    parameter int unsigned HAS_EXT = 1,
    parameter int unsigned LOSS_CYC = REF_LOSS_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Reference clock pins
    input wire logic primary_ref_in,
    input wire logic secondary_ref_in,
    input wire logic clkswitch_in,
    // Reconfiguration chain pins
    input wire logic scan_clk_in,
    input wire logic scan_data_in,
    input wire logic scan_en_in,
    input wire logic scan_clr_in,
    // Register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    // Status and clocks
    output logic lock_out,
    output logic active_ref_out,
    output logic ref_clk_out,
    output logic reconfig_busy_out,
    output logic [N_REG+N_GLB+N_EXT*HAS_EXT-1:0] post_clk_out
);
    localparam int unsigned NOUT = N_REG + N_GLB + N_EXT * HAS_EXT;
    localparam int unsigned CHAIN_LEN = 2 * NM_W + CFG_W * NOUT;
    localparam int unsigned CW = $clog2(CHAIN_LEN + 1);
    localparam int unsigned LW = $clog2(LOSS_CYC + 1);
    localparam int unsigned RW = $clog2(RELOCK_CYC + 1);

    if (HAS_EXT > 1) begin : g_bad_ext
        $error("HAS_EXT must be 0 or 1");
    end
    if (LOSS_CYC < 4) begin : g_bad_loss
        $error("LOSS_CYC too small to see a reference edge");
    end

    // Counter address decode shared by read and write
    function automatic logic [4:0] cnt_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ADDR_CNT0;
        if (a >= ADDR_CNT0 && off[1:0] == 2'h0 && off[ADDR_W-1:2] < ADDR_W'(NOUT))
            cnt_sel = {1'b1, off[5:2]};
        else
            cnt_sel = 5'h00;
    endfunction

    // ---------------- Pin synchronisers ----------------
    logic [SYNC_N-1:0] s1_q, s2_q, s3_q, st_q, st_d, rise;
    always_comb begin
        st_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & st_q);
        rise = st_d & ~st_q;
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            st_q <= '0;
        end else begin
            s1_q <= {scan_en_in, scan_data_in, scan_clk_in, clkswitch_in,
                     secondary_ref_in, primary_ref_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= st_d;
        end
    end

    // ---------------- Reconfiguration chain ----------------
    logic [CHAIN_LEN-1:0] chain_q, chain_d;
    logic [CW-1:0] bits_q, bits_d;
    logic load_q, load_d;
    always_comb begin
        chain_d = chain_q;
        bits_d = bits_q;
        load_d = 1'b0;
        if (rise[SY_SCLK] && st_q[SY_SEN]) begin
            chain_d = {chain_q[CHAIN_LEN-2:0], st_q[SY_SDAT]};
            if (bits_q == CW'(CHAIN_LEN - 1)) begin
                bits_d = '0;
                load_d = 1'b1;
            end else begin
                bits_d = bits_q + CW'(1);
            end
        end
    end
    // Clear acts without the clock so a stuck shift clock cannot block it
    always_ff @(posedge clk_in or posedge scan_clr_in) begin
        if (scan_clr_in) begin
            chain_q <= '0;
            bits_q <= '0;
            load_q <= 1'b0;
        end else if (!nrst_in) begin
            chain_q <= '0;
            bits_q <= '0;
            load_q <= 1'b0;
        end else begin
            chain_q <= chain_d;
            bits_q <= bits_d;
            load_q <= load_d;
        end
    end

    // ---------------- Register file ----------------
    logic [1:0] ctrl_q, ctrl_d;
    logic [NM_W-1:0] n_q, n_d, m_q, m_d;
    logic [7:0] bw_q, bw_d;
    pllsy_cnt_cfg_t cfg_q [NOUT];
    pllsy_cnt_cfg_t cfg_d [NOUT];
    logic [31:0] rd_q, rd_d;
    logic cfg_chg;
    logic [4:0] wsel, rsel;
    logic lock_q, sel_q, busy_q;
    logic [1:0] present;

    always_comb begin
        ctrl_d = ctrl_q;
        n_d = n_q;
        m_d = m_q;
        bw_d = bw_q;
        cfg_d = cfg_q;
        rd_d = '0;
        cfg_chg = 1'b0;
        wsel = cnt_sel(addr_in);
        rsel = cnt_sel(addr_in);
        if (wr_in) begin
            if (addr_in == ADDR_CTRL) begin
                ctrl_d = wr_data_in[1:0];
            end else if (addr_in == ADDR_NM) begin
                n_d = wr_data_in[NM_N_POS +: NM_W];
                m_d = wr_data_in[NM_M_POS +: NM_W];
                cfg_chg = 1'b1;
            end else if (addr_in == ADDR_BW) begin
                bw_d = wr_data_in[7:0];
                cfg_chg = 1'b1;
            end else if (wsel[4]) begin
                cfg_d[wsel[3:0]] = wr_data_in[CFG_W-1:0];
                cfg_chg = 1'b1;
            end
        end
        // Chain reaches dividers, duty modes, delays, m and n only; bandwidth stays put
        if (load_q) begin
            for (int i = 0; i < NOUT; i++) begin
                cfg_d[i] = chain_q[i*CFG_W +: CFG_W];
            end
            m_d = chain_q[NOUT*CFG_W +: NM_W];
            n_d = chain_q[NOUT*CFG_W+NM_W +: NM_W];
            cfg_chg = 1'b1;
        end
        if (rd_in) begin
            if (addr_in == ADDR_CTRL) begin
                rd_d[1:0] = ctrl_q;
            end else if (addr_in == ADDR_STATUS) begin
                rd_d[ST_LOCK_BIT] = lock_q;
                rd_d[ST_SEL_BIT] = sel_q;
                rd_d[ST_PRI_BIT] = present[0];
                rd_d[ST_SEC_BIT] = present[1];
                rd_d[ST_BUSY_BIT] = busy_q;
            end else if (addr_in == ADDR_NM) begin
                rd_d[NM_N_POS +: NM_W] = n_q;
                rd_d[NM_M_POS +: NM_W] = m_q;
            end else if (addr_in == ADDR_BW) begin
                rd_d[7:0] = bw_q;
            end else if (rsel[4]) begin
                rd_d[CFG_W-1:0] = cfg_q[rsel[3:0]];
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctrl_q <= CTRL_RST;
            n_q <= NM_RST;
            m_q <= NM_RST;
            bw_q <= BW_RST;
            rd_q <= '0;
            for (int i = 0; i < NOUT; i++) begin
                cfg_q[i] <= '{dly: '0, duty50: 1'b1, div: DIV_RST};
            end
        end else begin
            ctrl_q <= ctrl_d;
            n_q <= n_d;
            m_q <= m_d;
            bw_q <= bw_d;
            rd_q <= rd_d;
            cfg_q <= cfg_d;
        end
    end

    // ---------------- Reference sense and switchover ----------------
    logic [LW-1:0] loss_q [2];
    logic [LW-1:0] loss_d [2];
    logic sel_d, pend_q, pend_d, refo_q, refo_d, sw_evt;
    always_comb begin
        for (int r = 0; r < 2; r++) begin
            loss_d[r] = rise[r] ? '0 :
                        (loss_q[r] == LW'(LOSS_CYC)) ? loss_q[r] : loss_q[r] + LW'(1);
            present[r] = (loss_q[r] != LW'(LOSS_CYC));
        end
        sel_d = sel_q;
        pend_d = pend_q;
        sw_evt = 1'b0;
        if (rise[SY_SW]) begin
            pend_d = ~pend_q;
        end else if (ctrl_q[CTRL_AUTO_BIT] && !sel_q && !present[0] && present[1]) begin
            pend_d = 1'b1;
        end
        // Swap only while the new side sits low and the old side is low or lost, so no runt pulse escapes
        if (pend_q && !st_q[~sel_q] && (!st_q[sel_q] || !present[sel_q])) begin
            sel_d = ~sel_q;
            pend_d = 1'b0;
            sw_evt = 1'b1;
        end
        refo_d = st_q[sel_q];
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            loss_q[0] <= '0;
            loss_q[1] <= '0;
            sel_q <= 1'b0;
            pend_q <= 1'b0;
            refo_q <= 1'b0;
        end else begin
            loss_q <= loss_d;
            sel_q <= sel_d;
            pend_q <= pend_d;
            refo_q <= refo_d;
        end
    end

    // ---------------- Lock tracking ----------------
    typedef enum logic [1:0] {LK_OFF, LK_ACQ, LK_LOCKED} pllsy_lock_t;
    pllsy_lock_t lk_q, lk_d;
    logic [RW-1:0] rl_q, rl_d, rl_len;
    logic lock_d, busy_d;
    always_comb begin
        // More pump current settles faster; worst case stays at the limit
        rl_len = RW'(RELOCK_CYC) >> bw_q[BW_CP_POS +: 2];
        lk_d = lk_q;
        rl_d = rl_q;
        unique case (lk_q)
            LK_OFF: begin
                rl_d = '0;
                if (ctrl_q[CTRL_EN_BIT]) begin
                    lk_d = LK_ACQ;
                end
            end
            LK_ACQ: begin
                rl_d = rl_q + RW'(1);
                if (rl_q + RW'(1) >= rl_len && present[sel_q]) begin
                    lk_d = LK_LOCKED;
                end
            end
            LK_LOCKED: begin
                rl_d = '0;
            end
        endcase
        if (lk_q != LK_OFF && (sw_evt || cfg_chg || !present[sel_q])) begin
            lk_d = LK_ACQ;
            rl_d = '0;
        end
        if (!ctrl_q[CTRL_EN_BIT]) begin
            lk_d = LK_OFF;
        end
        lock_d = (lk_d == LK_LOCKED);
        busy_d = (bits_q != '0) || load_q;
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            lk_q <= LK_OFF;
            rl_q <= '0;
            lock_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            lk_q <= lk_d;
            rl_q <= rl_d;
            lock_q <= lock_d;
            busy_q <= busy_d;
        end
    end

    // ---------------- Post-scale dividers ----------------
    for (genvar g = 0; g < NOUT; g++) begin : g_post
        pllsy_div_if dif ();
        // Oscillator keeps running through switchover
        assign dif.cfg = cfg_q[g];
        assign dif.run = ctrl_q[CTRL_EN_BIT];
        pllsy_post_div u_div (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .dif(dif.div)
        );
        assign post_clk_out[g] = dif.clk_out;
    end

    assign rd_data_out = rd_q;
    assign lock_out = lock_q;
    assign active_ref_out = sel_q;
    assign ref_clk_out = refo_q;
    assign reconfig_busy_out = busy_q;
endmodule // pllsy_ctrl

/* File: rtl/pllsy_pkg.sv */
// Constants, register map and types for the PLL synthesis control block
package pllsy_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned RELOCK_US = 100;
    localparam int unsigned RELOCK_CYC = RELOCK_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RECONF_US = 20;
    localparam int unsigned SHIFT_HZ = 22_000_000;
    localparam int unsigned REF_LOSS_CYC = 64;
    // Widths and counts
    localparam int unsigned NM_W = 9;
    localparam int unsigned DIV_W = 10;
    localparam int unsigned DLY_W = 4;
    localparam int unsigned N_REG = 2;
    localparam int unsigned N_GLB = 4;
    localparam int unsigned N_EXT = 4;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned SYNC_N = 6;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_NM = 8'h08;
    localparam logic [7:0] ADDR_BW = 8'h0C;
    localparam logic [7:0] ADDR_CNT0 = 8'h10;
    // Field positions
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_AUTO_BIT = 1;
    localparam int unsigned NM_N_POS = 0;
    localparam int unsigned NM_M_POS = 16;
    localparam int unsigned BW_CP_POS = 0;
    localparam int unsigned BW_R_POS = 2;
    localparam int unsigned BW_C_POS = 5;
    localparam int unsigned ST_LOCK_BIT = 0;
    localparam int unsigned ST_SEL_BIT = 1;
    localparam int unsigned ST_PRI_BIT = 2;
    localparam int unsigned ST_SEC_BIT = 3;
    localparam int unsigned ST_BUSY_BIT = 4;
    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam logic [NM_W-1:0] NM_RST = 9'h001;
    localparam logic [7:0] BW_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 10'h001;
    // Synchroniser bit positions
    localparam int unsigned SY_PRI = 0;
    localparam int unsigned SY_SEC = 1;
    localparam int unsigned SY_SW = 2;
    localparam int unsigned SY_SCLK = 3;
    localparam int unsigned SY_SDAT = 4;
    localparam int unsigned SY_SEN = 5;

    typedef struct packed {
        logic [DLY_W-1:0] dly;
        logic duty50;
        logic [DIV_W-1:0] div;
    } pllsy_cnt_cfg_t;

    localparam int unsigned CFG_W = $bits(pllsy_cnt_cfg_t);
endpackage

/* File: rtl/pllsy_div_if.sv */
// Interface between the control core and one post-scale divider
`timescale 1ns/1ps
interface pllsy_div_if;
    import pllsy_pkg::*;
    pllsy_cnt_cfg_t cfg;
    logic run;
    logic clk_out;
    modport ctl (output cfg, output run, input clk_out);
    modport div (input cfg, input run, output clk_out);
endinterface

/* File: rtl/pllsy_post_div.sv */
// Post-scale divider with duty mode and output delay element
`timescale 1ns/1ps
module pllsy_post_div
    import pllsy_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Configuration and output
    pllsy_div_if.div dif
);
    logic [DIV_W:0] cnt_q, cnt_d, lim, hi_len;
    logic [(1<<DLY_W)-1:0] line_q, line_d;
    logic raw_q, raw_d, out_q, out_d;

    always_comb begin
        // 50% mode spans 1..1024, other duty 1..512 (code 0 = top)
        if (dif.cfg.duty50) begin
            lim = (dif.cfg.div == '0) ? 11'h400 : {1'b0, dif.cfg.div};
            hi_len = (lim + 11'h001) >> 1;
        end else begin
            lim = (dif.cfg.div[NM_W-1:0] == '0) ? 11'h200 : {2'h0, dif.cfg.div[NM_W-1:0]};
            hi_len = 11'h001;
        end
        cnt_d = (cnt_q + 11'h001 >= lim) ? '0 : cnt_q + 11'h001;
        raw_d = (cnt_d < hi_len);
        line_d = {line_q[(1<<DLY_W)-2:0], raw_q};
        out_d = (dif.cfg.dly == '0) ? raw_q : line_q[dif.cfg.dly - 4'h1];
        if (!dif.run) begin
            cnt_d = '0;
            raw_d = 1'b0;
            line_d = '0;
            out_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt_q <= '0;
            raw_q <= 1'b0;
            line_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            raw_q <= raw_d;
            line_q <= line_d;
            out_q <= out_d;
        end
    end

    assign dif.clk_out = out_q;
endmodule // pllsy_post_div

/* File: bench/pllsy_far_model.sv */
// Far-side model: reference oscillators, manual switch and chain shifter
`timescale 1ns/1ps
module pllsy_far_model (
    // Clock
    input wire logic clk_in,
    // Reference enables
    input wire logic pri_on_in,
    input wire logic sec_on_in,
    // Pins toward the block
    output logic primary_ref_out,
    output logic secondary_ref_out,
    output logic clkswitch_out,
    output logic scan_clk_out,
    output logic scan_data_out,
    output logic scan_en_out
);
    logic [2:0] ph_q;

    initial begin
        ph_q = 3'h0;
        primary_ref_out = 1'b0;
        secondary_ref_out = 1'b0;
        clkswitch_out = 1'b0;
        scan_clk_out = 1'b0;
        scan_data_out = 1'b0;
        scan_en_out = 1'b0;
    end

    // Refs differ by far more than 20%, so only a manual switch returns
    always @(posedge clk_in) begin
        ph_q <= ph_q + 3'h1;
        if (pri_on_in) primary_ref_out <= ph_q[2];
        if (sec_on_in) secondary_ref_out <= ph_q[1];
    end

    task automatic pulse_switch();
        @(posedge clk_in);
        clkswitch_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        clkswitch_out <= 1'b0;
    endtask

    // Shift clock stands still between frames
    task automatic shift(input logic [167:0] v, input int nb);
        int b;
        @(posedge clk_in);
        for (b = 167; b > 167 - nb; b--) begin
            scan_en_out <= 1'b1;
            scan_data_out <= v[b];
            repeat (4) @(posedge clk_in);
            scan_clk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            scan_clk_out <= 1'b0;
        end
        scan_en_out <= 1'b0;
        scan_data_out <= ~v[168 - nb];
    endtask
endmodule // pllsy_far_model

/* File: bench/pllsy_ctrl_asserts.sv */
// Checker for the PLL synthesis control top ports
`timescale 1ns/1ps
module pllsy_ctrl_asserts
    import pllsy_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scan_clr_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rd_data_out,
    input wire logic lock_out,
    input wire logic active_ref_out,
    input wire logic reconfig_busy_out
);
    logic [15:0] low_q;
    logic [15:0] low_d;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // Consecutive unlocked cycles, saturating
    always_comb begin
        low_d = lock_out ? 16'h0000 : ((low_q == 16'hFFFF) ? low_q : low_q + 16'h0001);
    end
    always_ff @(posedge clk_in) begin
        low_q <= nrst_in ? low_d : 16'h0000;
    end

    a_idle_rd_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
        else $error("read data not zero when idle");
    a_unmap_rd_zero: assert property (rd_in && addr_in == 8'hFC |=> rd_data_out == 32'h0)
        else $error("unmapped read not zero");
    a_bw_readback: assert property (wr_in && addr_in == ADDR_BW ##2 rd_in && addr_in == ADDR_BW
        |=> rd_data_out == {24'h0, $past(wr_data_in[7:0], 3)}) else $error("bandwidth readback wrong");
    a_cnt_upper_zero: assert property (rd_in && addr_in == ADDR_CNT0
        |=> rd_data_out[31:15] == 17'h0) else $error("counter read upper bits set");
    a_switch_unlock: assert property ($changed(active_ref_out) |-> !lock_out)
        else $error("lock high at switchover");
    a_load_unlock: assert property ($fell(reconfig_busy_out) && !scan_clr_in
        && !$past(scan_clr_in) |-> ##[0:3] !lock_out) else $error("lock kept after load");
    a_relock_min: assert property ($rose(lock_out) |-> low_q >= 16'h01EA)
        else $error("lock returned too early");
    a_clr_idle: assert property (scan_clr_in |=> !reconfig_busy_out)
        else $error("busy kept through clear");
endmodule // pllsy_ctrl_asserts

bind pllsy_ctrl pllsy_ctrl_asserts u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .scan_clr_in(scan_clr_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .lock_out(lock_out),
    .active_ref_out(active_ref_out), .reconfig_busy_out(reconfig_busy_out));

/* File: bench/pllsy_ctrl_test.sv */
// Self-checking bench for the PLL synthesis control block
`timescale 1ns/1ps
module pllsy_ctrl_test
    import pllsy_pkg::*;
();
    localparam int LIM = 700;
    logic clk_in, nrst_in, pri_on, sec_on, primary_ref_in, secondary_ref_in, clkswitch_in;
    logic scan_clk_in, scan_data_in, scan_en_in, scan_clr_in, wr_in, rd_in;
    logic [ADDR_W-1:0] addr_in;
    logic [31:0] wr_data_in, rd_data_out;
    logic lock_out, active_ref_out, ref_clk_out, reconfig_busy_out;
    logic [9:0] post_clk_out;
    int n_errors = 0;
    int num_checks = 0;

    pllsy_far_model far (.clk_in(clk_in), .pri_on_in(pri_on), .sec_on_in(sec_on),
        .primary_ref_out(primary_ref_in), .secondary_ref_out(secondary_ref_in),
        .clkswitch_out(clkswitch_in), .scan_clk_out(scan_clk_in),
        .scan_data_out(scan_data_in), .scan_en_out(scan_en_in));
    pllsy_ctrl dut (.clk_in(clk_in), .nrst_in(nrst_in), .primary_ref_in(primary_ref_in),
        .secondary_ref_in(secondary_ref_in), .clkswitch_in(clkswitch_in),
        .scan_clk_in(scan_clk_in), .scan_data_in(scan_data_in), .scan_en_in(scan_en_in),
        .scan_clr_in(scan_clr_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .lock_out(lock_out),
        .active_ref_out(active_ref_out), .ref_clk_out(ref_clk_out),
        .reconfig_busy_out(reconfig_busy_out), .post_clk_out(post_clk_out));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic timeout(input string nm);
        n_errors++;
        $display("MISMATCH %s expected done seen timeout", nm);
        report_and_stop();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(nm, e, rd_data_out);
    endtask

    function automatic logic obs(input int i);
        return (i == 0) ? lock_out : ((i == 1) ? active_ref_out : reconfig_busy_out);
    endfunction

    // Leaves just after an edge; bus tasks realign on their own
    task automatic wait_bit(input string nm, input int i, input logic v, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge clk_in);
            #1;
            if (obs(i) === v) break;
        end
        if (k == lim) timeout(nm);
        chk(nm, {31'h0, v}, {31'h0, obs(i)});
    endtask

    // High cycles over four periods, starting at a rising edge
    task automatic meas(input int i, input int per, input int hi);
        logic prv;
        logic [31:0] h;
        int k;
        prv = 1'b1;
        h = 32'h0;
        for (k = 0; k < 3000; k++) begin
            @(posedge clk_in);
            #1;
            if (prv === 1'b0 && post_clk_out[i] === 1'b1) break;
            prv = post_clk_out[i];
        end
        if (k == 3000) timeout("post_edge");
        repeat (4 * per) begin
            h = h + {31'h0, post_clk_out[i]};
            @(posedge clk_in);
            #1;
        end
        chk("post_high", 32'(4 * hi), h);
    endtask

    // Rising edges of the passed-on reference over 16 cycles
    task automatic ref_rises(input string nm, input logic [31:0] e);
        logic prv;
        logic [31:0] n;
        @(posedge clk_in);
        #1;
        prv = ref_clk_out;
        n = 32'h0;
        repeat (16) begin
            @(posedge clk_in);
            #1;
            if (prv === 1'b0 && ref_clk_out === 1'b1) n = n + 32'h1;
            prv = ref_clk_out;
        end
        chk(nm, e, n);
    endtask

    // Cycles from a rise of output a to the next rise of output b
    task automatic lag(input int a, input int b, input logic [31:0] e);
        logic prv;
        int k;
        prv = 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_in);
            #1;
            if (prv === 1'b0 && post_clk_out[a] === 1'b1) break;
            prv = post_clk_out[a];
        end
        if (k == 20) timeout("lag_edge");
        prv = post_clk_out[b];
        for (k = 0; k < 8; k++) begin
            @(posedge clk_in);
            #1;
            if (prv === 1'b0 && post_clk_out[b] === 1'b1) break;
            prv = post_clk_out[b];
        end
        chk("post_lag", e, 32'(k + 1));
    endtask

    task automatic t_reset();
        int i;
        rdchk("ctrl", ADDR_CTRL, 32'h3);
        rdchk("status_rst", ADDR_STATUS, 32'h0000_000C);
        rdchk("nm", ADDR_NM, 32'h0001_0001);
        rdchk("bw", ADDR_BW, 32'h0);
        for (i = 0; i < 10; i++) begin
            rdchk("cnt", ADDR_CNT0 + 8'(4 * i), 32'h401);
        end
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(ADDR_BW, 32'h3);
        rdchk("bw", ADDR_BW, 32'h3);
        wr(ADDR_NM, 32'h01FF_01FF);
        rdchk("nm_max", ADDR_NM, 32'h01FF_01FF);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        wr(8'hFC, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'hFC, 32'h0);
        rdchk("ctrl_kept", ADDR_CTRL, 32'h3);
        wr(ADDR_CTRL, 32'h0);
        rdchk("ctrl_off", ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h3);
        wait_bit("lock", 0, 1'b1, LIM);
        rdchk("status", ADDR_STATUS, 32'h0000_000D);
        $display("test regs done");
    endtask

    task automatic t_div();
        int ix [4] = '{0, 2, 5, 6};
        logic [31:0] wv [4] = '{32'h405, 32'h400, 32'h003, 32'h000};
        int per [4] = '{5, 1024, 3, 512};
        int hi [4] = '{3, 512, 1, 1};
        int j;
        for (j = 0; j < 4; j++) begin
            wr(ADDR_CNT0 + 8'(4 * ix[j]), wv[j]);
            meas(ix[j], per[j], hi[j]);
        end
        // Same period, second one written two cycles later with two cycles of delay
        wr(ADDR_CNT0 + 8'h0C, 32'h0000_0406);
        wr(ADDR_CNT0 + 8'h10, 32'h0000_1406);
        lag(3, 4, 32'h4);
        $display("test div done");
    endtask

    task automatic t_auto();
        pri_on <= 1'b0;
        wait_bit("active_sec", 1, 1'b1, 300);
        chk("lock_at_switch", 32'h0, {31'h0, lock_out});
        meas(0, 5, 3);
        wait_bit("relock", 0, 1'b1, LIM);
        ref_rises("ref_sec", 32'h4);
        $display("test auto done");
    endtask

    task automatic t_manual();
        pri_on <= 1'b1;
        // Primary must be seen again first, or auto sense would swap straight back
        repeat (80) @(posedge clk_in);
        rdchk("status_sec", ADDR_STATUS, 32'h0000_000F);
        far.pulse_switch();
        wait_bit("active_pri", 1, 1'b0, 300);
        wait_bit("relock", 0, 1'b1, LIM);
        ref_rises("ref_pri", 32'h2);
        $display("test manual done");
    endtask

    task automatic t_chain();
        far.shift({9'h002, 9'h003, {9{15'h0401}}, 15'h0406}, 168);
        wait_bit("busy_idle", 2, 1'b0, 20);
        rdchk("nm_chain", ADDR_NM, 32'h0003_0002);
        rdchk("cnt0_chain", ADDR_CNT0, 32'h0000_0406);
        rdchk("bw_kept", ADDR_BW, 32'h3);
        meas(0, 6, 3);
        wait_bit("relock", 0, 1'b1, LIM);
        far.shift({9'h004, 159'h0}, 20);
        wait_bit("busy_part", 2, 1'b1, 4);
        @(posedge clk_in);
        scan_clr_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        scan_clr_in <= 1'b0;
        wait_bit("busy_clr", 2, 1'b0, 4);
        rdchk("nm_kept", ADDR_NM, 32'h0003_0002);
        $display("test chain done");
    endtask

    initial begin
        nrst_in = 1'b0;
        pri_on = 1'b1;
        sec_on = 1'b1;
        scan_clr_in = 1'b0;
        addr_in = '0;
        wr_data_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset();
        t_regs();
        t_div();
        t_auto();
        t_manual();
        t_chain();
        report_and_stop();
    end
endmodule // pllsy_ctrl_test
